// [rtl/rxp_pkg.sv]
// constants, field layouts and carrier types of the per-port receive configuration bank
package rxp_pkg;

   localparam int unsigned NPORT = 8;
   localparam int unsigned ADDR_W = 14;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned LVL_W = 7;

   // register indices; byte address is four times the index
   localparam logic [11:0] IDX_ECR = 12'h086;
   localparam logic [11:0] IDX_HFC = 12'h087;
   localparam logic [11:0] IDX_IBC = 12'h088;
   localparam logic [11:0] IDX_SCC = 12'h089;
   localparam logic [11:0] IDX_XPC = 12'h08a;
   localparam logic [11:0] PORT_STRIDE = 12'h200;
   localparam int unsigned PORT_LSB = 9;
   localparam logic [11:0] IDX_INT_STAT = 12'hf00;
   localparam logic [11:0] IDX_INT_MASK = 12'hf01;

   // field positions
   localparam int unsigned ECR_SIGNAL_FBIT_ERR_REPORT_EN_BIT = 2;
   localparam int unsigned ECR_MOS_BIT = 1;
   localparam int unsigned ECR_LCV_BIT = 0;
   localparam int unsigned HFC_HWM_LSB = 0;
   localparam int unsigned IBC_IBS_LSB = 5;
   localparam int unsigned IBC_MODE_BIT = 4;
   localparam int unsigned IBC_EN_BIT = 3;
   localparam int unsigned IBC_SLOT_LSB = 0;
   localparam int unsigned SCC_LEN_LSB = 0;
   localparam int unsigned XPC_DIR_BIT = 2;
   localparam int unsigned XPC_FUS_BIT = 1;
   localparam int unsigned XPC_EN_BIT = 0;

   // watermark thresholds in bytes
   localparam logic [6:0] HWM_BYTES_0 = 7'h04;
   localparam logic [6:0] HWM_BYTES_1 = 7'h10;
   localparam logic [6:0] HWM_BYTES_2 = 7'h20;
   localparam logic [6:0] HWM_BYTES_3 = 7'h30;

   // interleave bus size codes and device counts
   localparam logic [1:0] IBS_TWO = 2'h0;
   localparam logic [1:0] IBS_FOUR = 2'h1;
   localparam logic [1:0] IBS_EIGHT = 2'h2;
   localparam logic [1:0] IBS_RSVD = 2'h3;
   localparam logic [3:0] DEV_TWO = 4'h2;
   localparam logic [3:0] DEV_FOUR = 4'h4;
   localparam logic [3:0] DEV_EIGHT = 4'h8;

   localparam logic [2:0] SPARE_LONG = 3'h7;
   localparam logic [3:0] SPARE_LONG_LEN = 4'h8;

   typedef struct packed {
      logic signal_fbit_err_report_en;
      logic mos_sel;
      logic lcv_sel;
      logic [1:0] hwm;
      logic [1:0] interleave_bus_size;
      logic ibo_frame;
      logic ibo_en;
      logic [2:0] slot;
      logic [2:0] spare;
      logic dir;
      logic fus;
      logic bit_error_tester_en;
   } rxp_cfg_t;

   localparam rxp_cfg_t CFG_RST = '0;

   typedef struct packed {
      logic t1_mode;
      logic ft_err;
      logic fs_err;
      logic mf_oos;
      logic lcv;
      logic exz;
      logic fbit_pos;
      logic framer_bit;
      logic tx_bit;
      logic [LVL_W-1:0] fifo_level;
   } rxp_line_in_t;

   typedef struct packed {
      logic fbit_err_inc;
      logic mos_cnt_inc;
      logic lcv_cnt_inc;
      logic hwm_reached;
      logic [6:0] hwm_bytes;
      logic ibo_active;
      logic ibo_frame_mode;
      logic [3:0] ibo_devices;
      logic [3:0] ibo_slot_num;
      logic spare_active;
      logic [3:0] spare_len;
      logic spare_len_8_16;
      logic bit_error_tester_active;
      logic bit_error_tester_clk_en;
      logic bit_error_tester_data;
   } rxp_line_out_t;

   localparam rxp_line_out_t LINE_RST = '0;

endpackage

// [rtl/rxp_regs.sv]
// per-port receive configuration register bank with Avalon-MM slave and interrupt
// What this block does
// R01: T1 with report select set: framing error counter also counts signaling framing bits.
// R02: T1 multiframe counter counts framing errors when clear, out-of-sync multiframes when set.
// R03: line violation counter adds excessive zeros only while its select is set.
// R04: watermark code 00/01/10/11 gives 4/16/32/48 bytes.
// R05: bus size code gives 2, 4 or 8 devices; code 11 is reserved.
// R06: interleave mode bit: clear is channel interleave, set is frame interleave.
// R07: interleaved bus runs only while the enable bit is set.
// R08: slot code k places this port at position k+1 on the bus.
// R09: T1 spare code length: codes 0..6 give 1..7 bits, code 7 gives 8 or 16.
// R10: tester direction clear: tester takes receive framer output.
// R11: tester direction set: tester takes transmit path ahead of the elastic store.
// R12: T1 tester skips the framing bit unless the unframed select is set.
// R13: each of eight ports has its own copy at base plus 200h per port.
// R14: tester port works only while its enable bit is set.
// R15: fifo watermark flag whenever fill level reaches or exceeds the threshold.
`timescale 1ns/100ps
module rxp_regs (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [rxp_pkg::ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [rxp_pkg::DATA_W-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [rxp_pkg::DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire rxp_pkg::rxp_line_in_t i_line [rxp_pkg::NPORT],
   output rxp_pkg::rxp_line_out_t o_line [rxp_pkg::NPORT],
   output logic o_irq
);

   localparam int unsigned NP = rxp_pkg::NPORT;

   // bus handshake: first cycle of a request stalls, second cycle answers
   logic ack_q;
   logic [7:0] rd_q;
   logic [7:0] rd_d;
   logic [NP-1:0] stat_q;
   logic [NP-1:0] stat_d;
   logic [NP-1:0] mask_q;
   logic [NP-1:0] mask_d;
   logic [NP-1:0] hwm_rise;

   rxp_pkg::rxp_cfg_t cfg_q [NP];
   rxp_pkg::rxp_cfg_t cfg_d [NP];
   rxp_pkg::rxp_line_out_t line_q [NP];
   rxp_pkg::rxp_line_out_t line_d [NP];

   wire req = i_avs_read | i_avs_write;
   wire aligned = (i_avs_address[1:0] == 2'h0);
   wire [11:0] idx = i_avs_address[rxp_pkg::ADDR_W-1:2];
   wire [2:0] port = idx[11:rxp_pkg::PORT_LSB];
   wire [11:0] off = {3'h0, idx[rxp_pkg::PORT_LSB-1:0]};
   wire wr_fire = i_avs_write & ack_q & i_avs_byteenable[0];
   wire [7:0] wd = i_avs_writedata[7:0];
   wire hit_stat = aligned && (idx == rxp_pkg::IDX_INT_STAT);
   wire hit_mask = aligned && (idx == rxp_pkg::IDX_INT_MASK);
   wire wr_stat = wr_fire && hit_stat;
   wire wr_mask = wr_fire && hit_mask;

   assign o_avs_waitrequest = req & ~ack_q;
   assign o_avs_readdata = {24'h000000, rd_q};
   assign o_irq = |(stat_q & mask_q);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // read data is sampled in the stall cycle so it stands when waitrequest drops
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rd_q <= 8'h00;
      end else if (i_avs_read && !ack_q) begin
         rd_q <= rd_d;
      end
   end

   function automatic logic [7:0] cfg_read(input rxp_pkg::rxp_cfg_t c, input logic [11:0] o);
      logic [7:0] r;
      r = 8'h00;
      unique case (o)
         rxp_pkg::IDX_ECR: begin
            r[rxp_pkg::ECR_SIGNAL_FBIT_ERR_REPORT_EN_BIT] = c.signal_fbit_err_report_en;
            r[rxp_pkg::ECR_MOS_BIT] = c.mos_sel;
            r[rxp_pkg::ECR_LCV_BIT] = c.lcv_sel;
         end
         rxp_pkg::IDX_HFC: r[rxp_pkg::HFC_HWM_LSB +: 2] = c.hwm;
         rxp_pkg::IDX_IBC: begin
            r[rxp_pkg::IBC_IBS_LSB +: 2] = c.interleave_bus_size;
            r[rxp_pkg::IBC_MODE_BIT] = c.ibo_frame;
            r[rxp_pkg::IBC_EN_BIT] = c.ibo_en;
            r[rxp_pkg::IBC_SLOT_LSB +: 3] = c.slot;
         end
         rxp_pkg::IDX_SCC: r[rxp_pkg::SCC_LEN_LSB +: 3] = c.spare;
         rxp_pkg::IDX_XPC: begin
            r[rxp_pkg::XPC_DIR_BIT] = c.dir;
            r[rxp_pkg::XPC_FUS_BIT] = c.fus;
            r[rxp_pkg::XPC_EN_BIT] = c.bit_error_tester_en;
         end
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // unmapped or misaligned addresses read as zero
   always_comb begin
      rd_d = 8'h00;
      if (hit_stat) begin
         rd_d = stat_q;
      end else if (hit_mask) begin
         rd_d = mask_q;
      end else if (aligned) begin
         rd_d = cfg_read(cfg_q[port], off); // [R13]
      end
   end

   function automatic logic [6:0] hwm_thresh(input logic [1:0] code);
      logic [6:0] t;
      t = rxp_pkg::HWM_BYTES_0;
      unique case (code)
         2'h0: t = rxp_pkg::HWM_BYTES_0;
         2'h1: t = rxp_pkg::HWM_BYTES_1;
         2'h2: t = rxp_pkg::HWM_BYTES_2;
         2'h3: t = rxp_pkg::HWM_BYTES_3;
      endcase
      return t;
   endfunction

   // the reserved size code reports no devices and keeps the bus off
   function automatic logic [3:0] bus_devices(input logic [1:0] code);
      logic [3:0] n;
      n = 4'h0;
      unique case (code)
         rxp_pkg::IBS_TWO: n = rxp_pkg::DEV_TWO;
         rxp_pkg::IBS_FOUR: n = rxp_pkg::DEV_FOUR;
         rxp_pkg::IBS_EIGHT: n = rxp_pkg::DEV_EIGHT;
         rxp_pkg::IBS_RSVD: n = 4'h0;
      endcase
      return n;
   endfunction

   for (genvar p = 0; p < NP; p++) begin : g_port
      wire sel = aligned && (port == 3'(p));
      wire wr_ecr = wr_fire && sel && (off == rxp_pkg::IDX_ECR); // [R13]
      wire wr_hfc = wr_fire && sel && (off == rxp_pkg::IDX_HFC);
      wire wr_ibc = wr_fire && sel && (off == rxp_pkg::IDX_IBC);
      wire wr_scc = wr_fire && sel && (off == rxp_pkg::IDX_SCC);
      wire wr_xpc = wr_fire && sel && (off == rxp_pkg::IDX_XPC);
      wire t1 = i_line[p].t1_mode;
      wire [6:0] thr = hwm_thresh(cfg_q[p].hwm); // [R04]
      wire bus_ok = (cfg_q[p].interleave_bus_size != rxp_pkg::IBS_RSVD);

      always_comb begin
         cfg_d[p] = cfg_q[p];
         if (wr_ecr) begin
            cfg_d[p].signal_fbit_err_report_en = wd[rxp_pkg::ECR_SIGNAL_FBIT_ERR_REPORT_EN_BIT];
            cfg_d[p].mos_sel = wd[rxp_pkg::ECR_MOS_BIT];
            cfg_d[p].lcv_sel = wd[rxp_pkg::ECR_LCV_BIT];
         end
         if (wr_hfc) begin
            cfg_d[p].hwm = wd[rxp_pkg::HFC_HWM_LSB +: 2];
         end
         if (wr_ibc) begin
            cfg_d[p].interleave_bus_size = wd[rxp_pkg::IBC_IBS_LSB +: 2];
            cfg_d[p].ibo_frame = wd[rxp_pkg::IBC_MODE_BIT];
            cfg_d[p].ibo_en = wd[rxp_pkg::IBC_EN_BIT];
            cfg_d[p].slot = wd[rxp_pkg::IBC_SLOT_LSB +: 3];
         end
         if (wr_scc) begin
            cfg_d[p].spare = wd[rxp_pkg::SCC_LEN_LSB +: 3];
         end
         if (wr_xpc) begin
            cfg_d[p].dir = wd[rxp_pkg::XPC_DIR_BIT];
            cfg_d[p].fus = wd[rxp_pkg::XPC_FUS_BIT];
            cfg_d[p].bit_error_tester_en = wd[rxp_pkg::XPC_EN_BIT];
         end
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            cfg_q[p] <= rxp_pkg::CFG_RST;
         end else begin
            cfg_q[p] <= cfg_d[p];
         end
      end

      always_comb begin
         line_d[p] = rxp_pkg::LINE_RST;
         // signaling framing errors only count in T1
         line_d[p].fbit_err_inc = i_line[p].ft_err
            | (t1 & cfg_q[p].signal_fbit_err_report_en & i_line[p].fs_err); // [R01]
         line_d[p].mos_cnt_inc = (t1 && cfg_q[p].mos_sel) ? i_line[p].mf_oos
            : i_line[p].ft_err; // [R02]
         line_d[p].lcv_cnt_inc = i_line[p].lcv
            | (cfg_q[p].lcv_sel & i_line[p].exz); // [R03]
         line_d[p].hwm_bytes = thr; // [R04]
         line_d[p].hwm_reached = (i_line[p].fifo_level >= thr); // [R15]
         line_d[p].ibo_devices = bus_devices(cfg_q[p].interleave_bus_size); // [R05]
         // a reserved size cannot be honoured, so the bus is held off
         line_d[p].ibo_active = cfg_q[p].ibo_en & bus_ok; // [R07] [R05]
         line_d[p].ibo_frame_mode = cfg_q[p].ibo_en & cfg_q[p].ibo_frame; // [R06]
         line_d[p].ibo_slot_num = {1'b0, cfg_q[p].slot} + 4'h1; // [R08]
         line_d[p].spare_active = t1; // [R09]
         line_d[p].spare_len_8_16 = (cfg_q[p].spare == rxp_pkg::SPARE_LONG); // [R09]
         line_d[p].spare_len = (cfg_q[p].spare == rxp_pkg::SPARE_LONG)
            ? rxp_pkg::SPARE_LONG_LEN : {1'b0, cfg_q[p].spare} + 4'h1; // [R09]
         line_d[p].bit_error_tester_active = cfg_q[p].bit_error_tester_en; // [R14]
         // tx_bit is tapped by the datapath ahead of the receive elastic store
         line_d[p].bit_error_tester_data = cfg_q[p].bit_error_tester_en
            & (cfg_q[p].dir ? i_line[p].tx_bit : i_line[p].framer_bit); // [R10] [R11] [R14]
         line_d[p].bit_error_tester_clk_en = cfg_q[p].bit_error_tester_en
            & ~(t1 & i_line[p].fbit_pos & ~cfg_q[p].fus); // [R12] [R14]
      end

      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            line_q[p] <= rxp_pkg::LINE_RST;
         end else begin
            line_q[p] <= line_d[p];
         end
      end

      assign o_line[p] = line_q[p];
      assign hwm_rise[p] = line_d[p].hwm_reached & ~line_q[p].hwm_reached; // [R15]
   end

   // a new watermark crossing wins over a write-one clear in the same cycle
   always_comb begin
      stat_d = (stat_q & ~(wr_stat ? wd : 8'h00)) | hwm_rise;
      mask_d = wr_mask ? wd : mask_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_q <= '0;
         mask_q <= '0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
      end
   end

endmodule // rxp_regs

// [verif/rxp_regs_chk.sv]
// port-level assertion checker for the receive configuration bank
`timescale 1ns/100ps
module rxp_regs_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [rxp_pkg::DATA_W-1:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire rxp_pkg::rxp_line_in_t i_line [rxp_pkg::NPORT],
   input wire rxp_pkg::rxp_line_out_t o_line [rxp_pkg::NPORT]
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_stall_first: assert property ($rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest)
      else $error("no stall on first request cycle");
   a_stall_once: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("stall longer than one cycle");
   a_read_upper: assert property (i_avs_read && !o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   // outputs are registered, so the guard skips the edge that still shows reset values
   for (genvar p = 0; p < rxp_pkg::NPORT; p++) begin : g_port
      a_fbit_count: assert property ($past(i_rst_n) && $past(i_line[p].ft_err) |-> o_line[p].fbit_err_inc)
         else $error("terminal framing error not counted");
      a_mf_count: assert property ($past(i_rst_n) && !$past(i_line[p].t1_mode)
         |-> o_line[p].mos_cnt_inc == $past(i_line[p].ft_err))
         else $error("multiframe counter source wrong");
      a_lcv_count: assert property ($past(i_rst_n) && !$past(i_line[p].exz)
         |-> o_line[p].lcv_cnt_inc == $past(i_line[p].lcv))
         else $error("line violation count wrong");
      a_hwm_value: assert property ($past(i_rst_n)
         |-> o_line[p].hwm_bytes inside {7'h04, 7'h10, 7'h20, 7'h30})
         else $error("watermark threshold not legal");
      a_hwm_flag: assert property ($past(i_rst_n)
         |-> o_line[p].hwm_reached == ($past(i_line[p].fifo_level) >= o_line[p].hwm_bytes))
         else $error("watermark flag wrong");
      a_bus_devices: assert property (o_line[p].ibo_active
         |-> o_line[p].ibo_devices inside {4'h2, 4'h4, 4'h8})
         else $error("bus size wrong while active");
      a_slot_range: assert property ($past(i_rst_n) |-> o_line[p].ibo_slot_num inside {[4'h1:4'h8]})
         else $error("slot number out of range");
      a_tester_off: assert property (!o_line[p].bit_error_tester_active
         |-> !o_line[p].bit_error_tester_data && !o_line[p].bit_error_tester_clk_en)
         else $error("tester runs while disabled");
   end
endmodule // rxp_regs_chk
bind rxp_regs rxp_regs_chk chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_line(i_line), .o_line(o_line));

// [verif/rxp_regs_tb.sv]
// self-checking bench for the receive configuration bank
`timescale 1ns/100ps
module rxp_regs_tb;
   logic i_clk, i_rst_n, rd, wr, wt, irq;
   logic [13:0] ad;
   logic [31:0] wd, rdat, q;
   logic [3:0] be;
   logic [7:0] d;
   logic [15:0] v;
   rxp_pkg::rxp_line_in_t l;
   rxp_pkg::rxp_line_in_t li [rxp_pkg::NPORT];
   rxp_pkg::rxp_line_out_t lo [rxp_pkg::NPORT];
   logic [7:0] cf [8][5];
   logic [7:0] mk [5] = '{8'h07, 8'h03, 8'h7f, 8'h07, 8'h07};
   int fail_count, checks, seed, cyc;
   rxp_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(ad), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wt), .i_line(li), .o_line(lo), .o_irq(irq));
   function automatic logic [13:0] ra(input int p, input int r);
      return {rxp_pkg::PORT_STRIDE * 12'(p) + 12'h086 + 12'(r), 2'b00};
   endfunction
   function automatic logic [6:0] thr(input logic [7:0] h);
      return (h[1:0] == 2'h0) ? 7'h04 : {h[1:0], 4'h0};
   endfunction
   function automatic rxp_pkg::rxp_line_out_t exp_out(input int p, input rxp_pkg::rxp_line_in_t n);
      rxp_pkg::rxp_line_out_t o;
      logic [7:0] e, b, s, x;
      e = cf[p][0];
      b = cf[p][2];
      s = cf[p][3];
      x = cf[p][4];
      o.fbit_err_inc = n.ft_err | (n.t1_mode & e[2] & n.fs_err);
      o.mos_cnt_inc = (n.t1_mode & e[1]) ? n.mf_oos : n.ft_err;
      o.lcv_cnt_inc = n.lcv | (e[0] & n.exz);
      o.hwm_bytes = thr(cf[p][1]);
      o.hwm_reached = n.fifo_level >= o.hwm_bytes;
      o.ibo_active = b[3] & (b[6:5] != 2'h3);
      o.ibo_frame_mode = b[3] & b[4];
      o.ibo_devices = (b[6:5] == 2'h3) ? 4'h0 : 4'h2 << b[6:5];
      o.ibo_slot_num = {1'b0, b[2:0]} + 4'h1;
      o.spare_active = n.t1_mode;
      o.spare_len = {1'b0, s[2:0]} + 4'h1;
      o.spare_len_8_16 = s[2:0] == 3'h7;
      o.bit_error_tester_active = x[0];
      o.bit_error_tester_data = x[0] & (x[2] ? n.tx_bit : n.framer_bit);
      o.bit_error_tester_clk_en = x[0] & ~(n.t1_mode & n.fbit_pos & ~x[1]);
      return o;
   endfunction
   task automatic stop_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_line(input int p, input rxp_pkg::rxp_line_out_t e);
      checks++;
      if (lo[p] !== e) begin
         fail_count++;
         $display("Error line %0d expected %h seen %h", p, e, lo[p]);
      end
   endtask
   // the master assumes no stall length; a wait ends when waitrequest drops or after 50 cycles
   task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] dt,
         input logic [3:0] b);
      int n;
      n = 0;
      // start on a fresh edge so every request rises just after a rising clock edge
      @(posedge i_clk);
      ad <= a;
      wr <= w;
      rd <= !w;
      wd <= {24'h0, dt};
      be <= b;
      do begin
         @(posedge i_clk);
         n++;
      end while (wt !== 1'b0 && n < 50);
      if (n >= 50) begin
         fail_count++;
         stop_test();
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [13:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00, 4'h1);
      cmp_word("readdata", e, q);
   endtask
   task automatic settle;
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      seed = 62;
      i_rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      ad = '0;
      wd = '0;
      be = 4'h1;
      foreach (li[p]) li[p] = '0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      settle();
      for (int p = 0; p < 8; p++) begin
         for (int r = 0; r < 5; r++) cf[p][r] = 8'h00;
         cmp_line(p, exp_out(p, li[p]));
         for (int r = 0; r < 5; r++) rdc(ra(p, r), 32'h0);
      end
      for (int it = 0; it < 24; it++) begin
         for (int p = 0; p < 8; p++) begin
            for (int r = 0; r < 5; r++) begin
               d = $random(seed);
               bus(1'b1, ra(p, r), d, 4'h1);
               cf[p][r] = d & mk[r];
            end
         end
         for (int p = 0; p < 8; p++) rdc(ra(p, it % 5), {24'h0, cf[p][it % 5]});
         for (int p = 0; p < 8; p++) begin
            v = $random(seed);
            l = v;
            // alternate random fill levels with the threshold and one below it
            if (it % 2 == 0) l.fifo_level = thr(cf[p][1]) - 7'(it % 4 / 2);
            li[p] <= l;
         end
         settle();
         for (int p = 0; p < 8; p++) cmp_line(p, exp_out(p, li[p]));
         cmp_word("irq", 32'h0, {31'h0, irq});
      end
      rdc(14'h3000, 32'h0);
      rdc(ra(2, 2) | 14'h1, 32'h0);
      bus(1'b1, ra(2, 2), 8'h55, 4'h0);
      rdc(ra(2, 2), {24'h0, cf[2][2]});
      foreach (li[p]) li[p] <= '0;
      settle();
      bus(1'b1, {rxp_pkg::IDX_INT_STAT, 2'b00}, 8'hff, 4'h1);
      rdc({rxp_pkg::IDX_INT_STAT, 2'b00}, 32'h0);
      li[3].fifo_level <= 7'h7f;
      settle();
      rdc({rxp_pkg::IDX_INT_STAT, 2'b00}, 32'h8);
      cmp_word("irq", 32'h0, {31'h0, irq});
      bus(1'b1, {rxp_pkg::IDX_INT_MASK, 2'b00}, 8'h08, 4'h1);
      #1;
      cmp_word("irq", 32'h1, {31'h0, irq});
      bus(1'b1, {rxp_pkg::IDX_INT_STAT, 2'b00}, 8'h08, 4'h1);
      #1;
      cmp_word("irq", 32'h0, {31'h0, irq});
      rdc({rxp_pkg::IDX_INT_MASK, 2'b00}, 32'h8);
      stop_test();
   end
endmodule // rxp_regs_tb
